//--- core/adcsf_status.v
// Purpose: status flag register of a multichannel sigma-delta converter
// Assumes: framing logic on core_clk decodes serial frames into strobes;
//   only the chip-select pin arrives from outside the clock domain
// Notes: all outputs are registered; synchronous active-high reset
//
// Behaviour
// - idle chip-selected data-out shows ready flag
// - new result clears ready flag low
// - calibration mode: calibration result clears ready
// - data register read sets ready high
// - bit six flags overrange or underrange
// - clamp result to full or zero scale
// - range flag changes only on result write
// - bit five flags write checksum mismatch
// - status read clears checksum error flag
// - bit four flags register contents changed
// - enabling integrity check captures reference value
// - integrity flag clears only when check disabled
// - channel field names result's source channel
// - channel field is plain binary number
// - append enable adds status byte to data register reads
// - status at address zero, resets to 0x80
// - mode write returns ready flag high
`timescale 1ns/1ps
`include "adcsf_consts.vh"

module adcsf_status (
  input wire core_clk,
  input wire sys_rst,
  // chip select pin, asynchronous to core_clk
  input wire cs_n_pin,
  // framing logic: a register read is shifting out, and its current bit
  input wire reg_read_busy,
  input wire reg_read_bit,
  // framing logic: decoded accesses, one-cycle pulses
  input wire reg_rd_stb,
  input wire [5:0] reg_rd_addr,
  input wire data_rd_stb,
  input wire mode_wr_stb,
  input wire crc_wr_err_stb,
  // interface mode controls, levels
  input wire append_stat_en,
  input wire reg_check_en,
  // running signature over all internal registers
  input wire [`ADCSF_SIG_W-1:0] reg_signature,
  // conversion datapath
  input wire result_stb,
  input wire [`ADCSF_RESULT_W-1:0] result_raw,
  input wire result_over,
  input wire result_under,
  input wire [3:0] result_chan,
  input wire cal_mode,
  input wire cal_done_stb,
  // register and data outputs
  output reg [`ADCSF_STATUS_W-1:0] status_out_reg,
  output reg [`ADCSF_RESULT_W-1:0] data_reg,
  output reg [`ADCSF_WORD_W-1:0] read_word_reg,
  output reg [5:0] read_len_reg,
  output reg read_word_valid_reg,
  // data-out pin, three-state as output plus enable
  output reg dout_o_reg,
  output reg dout_oe_reg
);

  // chip select synchroniser; the first stage feeds only the second
  reg cs_meta_reg;
  reg cs_sync_reg;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n_pin;
      cs_sync_reg <= cs_meta_reg;
    end
  end

  // flag state
  reg rdy_reg;
  reg rdy_next;
  reg range_err_reg;
  reg range_err_next;
  reg crc_err_reg;
  reg crc_err_next;
  reg reg_err_reg;
  reg reg_err_next;
  reg [3:0] chan_reg;
  reg [3:0] chan_next;
  reg [`ADCSF_RESULT_W-1:0] data_next;

  // integrity check reference
  reg [`ADCSF_SIG_W-1:0] ref_sig_reg;
  reg check_armed_reg;
  reg check_en_d_reg;

  wire status_rd;
  wire conv_write;
  wire ready_event;
  wire check_rise;
  wire [`ADCSF_STATUS_W-1:0] status_now;

  assign status_rd = reg_rd_stb && (reg_rd_addr == `ADCSF_STATUS_ADDR);
  // a calibration result does not land in the data register
  assign conv_write = result_stb && !cal_mode;
  assign ready_event = cal_mode ? cal_done_stb : result_stb;
  assign check_rise = reg_check_en && !check_en_d_reg;

  assign status_now = {rdy_reg, range_err_reg, crc_err_reg, reg_err_reg, chan_reg};

  // ready flag: a mode write restarts conversion and outranks everything;
  // a fresh result outranks a data read in the same cycle so it is not lost
  always @* begin
    rdy_next = rdy_reg;
    if (mode_wr_stb) begin
      rdy_next = 1'b1;
    end else if (ready_event) begin
      rdy_next = 1'b0;
    end else if (data_rd_stb) begin
      rdy_next = 1'b1;
    end
  end

  // range flag, channel and clamped data move only with a conversion result
  always @* begin
    range_err_next = range_err_reg;
    chan_next = chan_reg;
    data_next = data_reg;
    if (conv_write) begin
      range_err_next = result_over || result_under;
      chan_next = result_chan;
      if (result_over) begin
        data_next = `ADCSF_FULL_SCALE;
      end else if (result_under) begin
        data_next = `ADCSF_ZERO_SCALE;
      end else begin
        data_next = result_raw;
      end
    end
  end

  // checksum flag: a new error in the clearing cycle wins over the read
  always @* begin
    crc_err_next = crc_err_reg;
    if (crc_wr_err_stb) begin
      crc_err_next = 1'b1;
    end else if (status_rd) begin
      crc_err_next = 1'b0;
    end
  end

  // integrity flag is sticky while the check stays enabled
  always @* begin
    reg_err_next = reg_err_reg;
    if (!reg_check_en) begin
      reg_err_next = 1'b0;
    end else if (check_armed_reg && (reg_signature != ref_sig_reg)) begin
      reg_err_next = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      rdy_reg <= `ADCSF_RDY_RESET;
      range_err_reg <= `ADCSF_ERR_RESET;
      crc_err_reg <= `ADCSF_ERR_RESET;
      reg_err_reg <= `ADCSF_ERR_RESET;
      chan_reg <= `ADCSF_CHAN_RESET;
      data_reg <= `ADCSF_ZERO_SCALE;
    end else begin
      rdy_reg <= rdy_next;
      range_err_reg <= range_err_next;
      crc_err_reg <= crc_err_next;
      reg_err_reg <= reg_err_next;
      chan_reg <= chan_next;
      data_reg <= data_next;
    end
  end

  // reference is taken on the enabling edge; comparison starts a cycle
  // later so the capture cycle itself cannot raise a false error
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ref_sig_reg <= {`ADCSF_SIG_W{1'b0}};
      check_armed_reg <= 1'b0;
      check_en_d_reg <= 1'b0;
    end else begin
      check_en_d_reg <= reg_check_en;
      if (check_rise) begin
        ref_sig_reg <= reg_signature;
      end
      check_armed_reg <= reg_check_en;
    end
  end

  // status image for the register read path
  always @(posedge core_clk) begin
    if (sys_rst) begin
      status_out_reg <= `ADCSF_STATUS_RESET;
    end else begin
      status_out_reg <= {rdy_next, range_err_next, crc_err_next, reg_err_next, chan_next};
    end
  end

  // data read word: status sampled as it stood before the read, so the
  // ready bit shows 0 for the result being fetched
  always @(posedge core_clk) begin
    if (sys_rst) begin
      read_word_reg <= {`ADCSF_WORD_W{1'b0}};
      read_len_reg <= `ADCSF_LEN_PLAIN;
      read_word_valid_reg <= 1'b0;
    end else begin
      read_word_valid_reg <= data_rd_stb;
      if (data_rd_stb) begin
        if (append_stat_en) begin
          read_word_reg <= {data_reg, status_now};
          read_len_reg <= `ADCSF_LEN_APPEND;
        end else begin
          read_word_reg <= {8'h00, data_reg};
          read_len_reg <= `ADCSF_LEN_PLAIN;
        end
      end
    end
  end

  // data-out pin: ready level while selected and idle, read bits while
  // shifting, released while deselected
  always @(posedge core_clk) begin
    if (sys_rst) begin
      dout_o_reg <= 1'b1;
      dout_oe_reg <= 1'b0;
    end else begin
      dout_oe_reg <= !cs_sync_reg;
      if (reg_read_busy) begin
        dout_o_reg <= reg_read_bit;
      end else begin
        dout_o_reg <= rdy_next;
      end
    end
  end

endmodule // adcsf_status

//--- core/adcsf_consts.vh
// Purpose: constants of the converter status flag register
// Assumes: included by its bare name
// Notes: definitions only
`ifndef ADCSF_CONSTS_VH
`define ADCSF_CONSTS_VH

// register address within the six-bit address space
`define ADCSF_STATUS_ADDR 6'h00
`define ADCSF_STATUS_RESET 8'h80

// field positions
`define ADCSF_BIT_RDY 7
`define ADCSF_BIT_RANGE_ERR 6
`define ADCSF_BIT_CRC_ERR 5
`define ADCSF_BIT_REG_ERR 4
`define ADCSF_CHAN_MSB 3
`define ADCSF_CHAN_LSB 0

// field reset values
`define ADCSF_RDY_RESET 1'b1
`define ADCSF_ERR_RESET 1'b0
`define ADCSF_CHAN_RESET 4'h0

// widths
`define ADCSF_RESULT_W 24
`define ADCSF_SIG_W 16
`define ADCSF_STATUS_W 8
`define ADCSF_WORD_W 32

// clamp codes
`define ADCSF_FULL_SCALE 24'h0fffff
`define ADCSF_ZERO_SCALE 24'h000000

// data read lengths in bits
`define ADCSF_LEN_PLAIN 6'h18
`define ADCSF_LEN_APPEND 6'h20

`endif

//--- bench/adcsf_status_assertions.sv
// Purpose: port-level checks of the status flag register
// Assumes: strobes sampled on core_clk, effects one cycle later
// Notes: ready priority cases excluded here are not driven by the bench either
`timescale 1ns/1ps
module adcsf_status_assertions (
  input logic core_clk, sys_rst, result_stb, cal_mode, cal_done_stb, mode_wr_stb,
  input logic data_rd_stb, crc_wr_err_stb, reg_rd_stb, result_over, result_under, reg_check_en,
  input logic [5:0] reg_rd_addr,
  input logic [3:0] result_chan,
  input logic [7:0] status_out_reg,
  input logic [23:0] data_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire [7:0] s = status_out_reg;
  wire conv = result_stb && !cal_mode;
  // the image shows the next value, so the enable must still stand a cycle on
  sequence err_up;
    s[4] && reg_check_en ##1 reg_check_en;
  endsequence
  rdy_low_a: assert property (conv && !mode_wr_stb |=> !s[7]) else $error("rdy");
  cal_low_a: assert property (cal_mode && cal_done_stb && !mode_wr_stb |=> !s[7])
    else $error("cal");
  rdy_high_a: assert property (data_rd_stb && !result_stb && !cal_done_stb |=> s[7])
    else $error("read");
  range_flag_a: assert property (conv |=> s[6] == $past(result_over || result_under))
    else $error("range");
  range_hold_a: assert property (!conv |=> $stable(s[6])) else $error("hold");
  clamp_code_a: assert property (conv && (result_over || result_under) |=>
    data_reg == ($past(result_over) ? 24'h0fffff : 24'h000000)) else $error("clamp");
  crc_set_a: assert property (crc_wr_err_stb |=> s[5]) else $error("crc");
  crc_clear_a: assert property (reg_rd_stb && reg_rd_addr == 6'h00 && !crc_wr_err_stb
    |=> !s[5]) else $error("crc clr");
  integ_keep_a: assert property (err_up |-> s[4]) else $error("integ");
  integ_clear_a: assert property (!reg_check_en |=> !s[4]) else $error("integ clr");
  chan_field_a: assert property (conv |=> s[3:0] == $past(result_chan))
    else $error("chan");
  mode_rdy_a: assert property (mode_wr_stb |=> s[7]) else $error("mode");
endmodule // adcsf_status_assertions
bind adcsf_status adcsf_status_assertions adcsf_status_assertions_i (.core_clk, .sys_rst,
  .result_stb, .cal_mode, .cal_done_stb, .mode_wr_stb, .data_rd_stb, .crc_wr_err_stb,
  .reg_rd_stb, .result_over, .result_under, .reg_check_en, .reg_rd_addr, .result_chan,
  .status_out_reg, .data_reg);

//--- bench/adcsf_host_model.sv
// Purpose: host and framing side of the serial port
// Assumes: tasks called from the bench, lines change at falling edges
// Notes: shifted bit toggles so a stale level never passes
`timescale 1ns/1ps
module adcsf_host_model (
  input wire core_clk,
  output reg cs_n_pin = 1, reg_read_busy = 0, reg_read_bit = 0,
  output reg reg_rd_stb = 0, data_rd_stb = 0,
  output reg [5:0] reg_rd_addr = 6'h3f
);
  task select(input sel);
    @(negedge core_clk);
    cs_n_pin = ~sel;
  endtask
  // read checksums are judged on this side
  task read_reg(input [5:0] a);
    @(negedge core_clk);
    {reg_rd_stb, reg_rd_addr} = {1'b1, a};
    repeat (3) begin
      @(negedge core_clk);
      {reg_rd_stb, reg_read_busy, reg_read_bit} = {2'b01, ~reg_read_bit};
    end
    @(negedge core_clk);
    reg_read_busy = 0;
  endtask
  task read_data;
    @(negedge core_clk);
    data_rd_stb = 1;
    @(negedge core_clk);
    data_rd_stb = 0;
  endtask
endmodule // adcsf_host_model

//--- bench/testbench.sv
// Purpose: self-checking bench of the status flag register
// Assumes: inputs change at falling edges, seed 64
// Notes: random results plus checksum, calibration and integrity corners
`timescale 1ns/1ps
module testbench;
  reg core_clk = 0, sys_rst = 1, mode_wr_stb = 0, crc_wr_err_stb = 0, cal_done_stb = 0;
  reg append_stat_en = 0, reg_check_en = 0, cal_mode = 0, result_stb = 0;
  reg result_over = 0, result_under = 0;
  reg [15:0] reg_signature = 16'h0000;
  reg [23:0] result_raw = 24'h000000;
  reg [3:0] result_chan = 4'h0;
  wire cs_n_pin, reg_read_busy, reg_read_bit, reg_rd_stb, data_rd_stb;
  wire read_word_valid_reg, dout_o_reg, dout_oe_reg;
  wire [5:0] reg_rd_addr, read_len_reg;
  wire [7:0] status_out_reg;
  wire [23:0] data_reg;
  wire [31:0] read_word_reg;
  integer err_count = 0, n_tests = 0, seed = 64, i;
  reg [31:0] rn;
  reg [7:0] e_s;
  adcsf_status adcsf_status_i (.core_clk, .sys_rst, .cs_n_pin, .reg_read_busy, .reg_read_bit,
    .reg_rd_stb, .reg_rd_addr, .data_rd_stb, .mode_wr_stb, .crc_wr_err_stb, .append_stat_en,
    .reg_check_en, .reg_signature, .result_stb, .result_raw, .result_over, .result_under,
    .result_chan, .cal_mode, .cal_done_stb, .status_out_reg, .data_reg, .read_word_reg,
    .read_len_reg, .read_word_valid_reg, .dout_o_reg, .dout_oe_reg);
  adcsf_host_model adcsf_host_model_i (.core_clk, .cs_n_pin, .reg_read_busy, .reg_read_bit,
    .reg_rd_stb, .data_rd_stb, .reg_rd_addr);
  initial forever #20 core_clk = ~core_clk;
  function [23:0] clamp(input [23:0] r, input o, u);
    clamp = o ? 24'h0fffff : (u ? 24'h000000 : r);
  endfunction
  task chk(input [39:0] e, s, input string n);
    n_tests = n_tests + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task pulse(input [2:0] w);
    @(negedge core_clk);
    {mode_wr_stb, crc_wr_err_stb, cal_done_stb} = w;
    @(negedge core_clk);
    {mode_wr_stb, crc_wr_err_stb, cal_done_stb} = 3'h0;
  endtask
  // over and under never both high, the clamp between them is unspecified
  task conv(input [31:0] v);
    @(negedge core_clk);
    {result_raw, result_chan, result_stb} = {v[31:8], v[7:4], 1'b1};
    {result_over, result_under} = {v[0] & v[1], v[2] & ~v[0]};
    @(negedge core_clk);
    result_stb = 0;
  endtask
  task give_verdict;
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 0;
    adcsf_host_model_i.read_reg(6'h00);
    chk(8'h80, status_out_reg, "reset");
    adcsf_host_model_i.select(1);
    repeat (4) @(negedge core_clk);
    chk(2'b11, {dout_oe_reg, dout_o_reg}, "dout idle");
    for (i = 0; i < 30; i = i + 1) begin
      rn = $random(seed);
      if (i < 2) rn[2:0] = i ? 3'h4 : 3'h3;
      conv(rn);
      e_s = {1'b0, result_over | result_under, 2'b00, rn[7:4]};
      chk(e_s, status_out_reg, "status");
      chk(clamp(rn[31:8], result_over, result_under), data_reg, "data");
      chk(1'b0, dout_o_reg, "dout rdy");
      append_stat_en = rn[3];
      adcsf_host_model_i.read_data;
      chk(e_s | 8'h80, status_out_reg, "rdy high");
      // the read word is flagged valid for one cycle only, so look now
      chk(rn[3] ? {7'h60, clamp(rn[31:8], result_over, result_under), e_s}
        : {7'h58, 8'h00, clamp(rn[31:8], result_over, result_under)},
        {read_word_valid_reg, read_len_reg, read_word_reg}, "word");
      adcsf_host_model_i.read_reg(rn[13:8]);
      chk(e_s | 8'h80, status_out_reg, "reg read");
    end
    pulse(3'b010);
    chk(e_s | 8'ha0, status_out_reg, "crc set");
    adcsf_host_model_i.read_reg(6'h00);
    chk(e_s | 8'h80, status_out_reg, "crc clr");
    cal_mode = 1;
    conv(32'h12345601);
    chk(e_s | 8'h80, status_out_reg, "cal conv");
    pulse(3'b001);
    chk(e_s, status_out_reg, "cal done");
    pulse(3'b100);
    chk(e_s | 8'h80, status_out_reg, "mode wr");
    {cal_mode, reg_check_en, reg_signature} = {2'b01, 16'h5a5a};
    repeat (3) @(negedge core_clk);
    chk(e_s | 8'h80, status_out_reg, "integ ok");
    reg_signature = 16'h5a5b;
    repeat (2) @(negedge core_clk);
    chk(e_s | 8'h90, status_out_reg, "integ set");
    reg_check_en = 0;
    repeat (2) @(negedge core_clk);
    chk(e_s | 8'h80, status_out_reg, "integ clr");
    give_verdict;
  end
endmodule // testbench
